// >>> src/qpc_host.sv
// host controller for a quad digital potentiometer on a 2-wire bus
// assumes an AHB-Lite master on hclk and a pulled-up open-drain sda line
//
// Functional notes
// - wiper read: opcode 1001, selects 00, pot pair, device returns byte msb first
// - wiper write: opcode 1010, selects 00, pot pair, then eight bits msb first
// - stored read: opcode 1011, stored pair, pot pair, byte returned msb first
// - stored write: opcode 1100, both pairs, byte; device writes nonvolatile after stop
// - global load: two bytes, opcode 0001, stored pair, pot bits zero
// - global save: two bytes, opcode 1000, stored pair, pot bits zero
// - single save: two bytes, opcode 1110, stored pair and pot pair
// - single load: two bytes, opcode 1101, stored pair and pot pair
// - stepping: opcode 0010, selects 00, pot pair, then step pulses, then stop
// - clock high with data high steps the wiper up one tap
// - clock high with data low steps the wiper down one tap
// - first byte is type nibble then four address bits msb first
// - device acks id, instruction, write data; master acks read data
// - don't-care bit positions are driven as zero
`timescale 1ns/1ps
module qpc_host
	import qpc_pkg::*;
#(
	parameter logic [3:0] DEV_TYPE = 4'h6, // arbitrary value, set to the part's type nibble
	parameter int STEP_W = 16,
	parameter int QUARTER_CYC = qpc_pkg::QPC_QUARTER_CYC
) (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic [31:0] hrdata,
	output logic hreadyout,
	output logic hresp,
	output logic scl_o,
	input wire logic sda_i,
	output logic sda_o,
	output logic sda_oe
);
	import qpc_pkg::*;

	initial begin
		if (STEP_W < 1 || STEP_W > 16) $error("qpc_host: STEP_W must be 1..16");
		if (QUARTER_CYC < 2) $error("qpc_host: QUARTER_CYC must be at least 2");
		// the quarter divider is sixteen bits wide
		if (QUARTER_CYC > 65536) $error("qpc_host: QUARTER_CYC must be at most 65536");
	end

	// ************************************************************
	// declarations
	// ************************************************************
	logic [31:0] cmd_q;
	logic [31:0] step_q;
	logic [7:0] wr_off_q;
	logic wr_pend_q;
	logic [15:0] div_q;
	logic tick;
	logic sda_s;
	qpc_state_t state_q, state_d;
	logic [1:0] phase_q, phase_d;
	logic [2:0] bitn_q, bitn_d;
	logic [1:0] bidx_q, bidx_d;
	logic [7:0] sh_q, sh_d;
	logic [STEP_W-1:0] cnt_q, cnt_d;
	logic scl_d;
	logic low_q, low_d;
	logic nack_q, nack_d;
	logic badop_q, badop_d;
	logic [7:0] rdata_q, rdata_d;
	logic busy_q, busy_d;
	logic rx_q, rx_d;

	// ************************************************************
	// bus decode
	// ************************************************************
	wire addr_phase = hsel & hready & htrans[1];
	wire word_acc = (hsize == 3'b010);
	wire [7:0] acc_off = haddr[7:0];
	wire do_write = wr_pend_q;
	wire wr_cmd = do_write & (wr_off_q == QPC_CMD_OFF);
	wire wr_step = do_write & (wr_off_q == QPC_STEP_OFF);
	wire go_req = wr_cmd & hwdata[QPC_CMD_GO_BIT];
	wire [31:0] stat_word = {16'h0000, rdata_q, 5'h00, badop_q, nack_q, busy_q};
	wire [31:0] rd_word = (acc_off == QPC_CMD_OFF) ? cmd_q :
		(acc_off == QPC_STEP_OFF) ? step_q :
		(acc_off == QPC_STAT_OFF) ? stat_word : 32'h0000_0000;

	// ************************************************************
	// frame decode from the command word
	// ************************************************************
	wire [3:0] op = cmd_q[3:0];
	wire [1:0] st_sel = cmd_q[5:4];
	wire [1:0] pot_sel = cmd_q[7:6];
	wire [7:0] wr_byte = cmd_q[15:8];
	wire [3:0] slave_adr = cmd_q[19:16];
	wire [3:0] hw_op = hwdata[3:0];
	wire op_ok = (hw_op == QPC_OP_RD_WIPER) | (hw_op == QPC_OP_WR_WIPER) |
		(hw_op == QPC_OP_RD_STORED) | (hw_op == QPC_OP_WR_STORED) |
		(hw_op == QPC_OP_LOAD_ONE) | (hw_op == QPC_OP_SAVE_ONE) |
		(hw_op == QPC_OP_LOAD_ALL) | (hw_op == QPC_OP_SAVE_ALL) |
		(hw_op == QPC_OP_STEP);
	wire op_read = (op == QPC_OP_RD_WIPER) | (op == QPC_OP_RD_STORED);
	wire op_three = op_read | (op == QPC_OP_WR_WIPER) | (op == QPC_OP_WR_STORED);
	wire op_step = (op == QPC_OP_STEP);
	// stored pair unused by wiper and step frames, sent as zero
	wire sel_zero = (op == QPC_OP_RD_WIPER) | (op == QPC_OP_WR_WIPER) | op_step;
	// global transfers carry zero pot bits
	wire pot_zero = (op == QPC_OP_LOAD_ALL) | (op == QPC_OP_SAVE_ALL);
	wire [7:0] id_byte = {DEV_TYPE, slave_adr};
	wire [7:0] ins_byte = {op, sel_zero ? 2'b00 : st_sel, pot_zero ? 2'b00 : pot_sel};
	wire last_byte = op_three ? (bidx_q == 2'd2) : (bidx_q == 2'd1);
	wire step_up = step_q[QPC_STEP_UP_BIT];

	// ************************************************************
	// sda input crosses into hclk
	// ************************************************************
	qpc_sync #(
		.WIDTH(1)
	) u_sda_sync (
		.clk(hclk),
		.rst_n(hresetn),
		.async_in(sda_i),
		.sync_out(sda_s)
	);

	// ************************************************************
	// ahb-lite slave, zero wait states, always okay
	// ************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_q <= 1'b0;
			wr_off_q <= 8'h00;
			hrdata <= 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end else begin
			wr_pend_q <= addr_phase & hwrite & word_acc;
			wr_off_q <= acc_off;
			hrdata <= (addr_phase & ~hwrite) ? rd_word : 32'h0000_0000;
			hreadyout <= 1'b1;
			hresp <= 1'b0;
		end
	end

	// command is frozen while a frame runs, so a stray write cannot bend it
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd_q <= QPC_CMD_RST;
			step_q <= QPC_STEP_RST;
		end else begin
			if (wr_cmd & ~busy_q) cmd_q <= {1'b0, 11'h000, hwdata[19:0]};
			if (wr_step & ~busy_q) step_q <= {15'h0000, hwdata[16:0]};
		end
	end

	// ************************************************************
	// quarter-bit divider, runs only during a frame
	// ************************************************************
	assign tick = busy_q & (div_q == 16'h0000);

	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) div_q <= 16'h0000;
		else if (!busy_q || tick) div_q <= 16'(QUARTER_CYC - 1);
		else div_q <= div_q - 16'h0001;
	end

	// ************************************************************
	// frame sequencer next state
	// ************************************************************
	always_comb begin
		state_d = state_q;
		phase_d = phase_q;
		bitn_d = bitn_q;
		bidx_d = bidx_q;
		sh_d = sh_q;
		cnt_d = cnt_q;
		scl_d = scl_o;
		low_d = low_q;
		nack_d = nack_q;
		badop_d = badop_q;
		rdata_d = rdata_q;
		busy_d = busy_q;
		rx_d = rx_q;
		if (state_q == QPC_IDLE) begin
			if (go_req) begin
				badop_d = ~op_ok;
				if (op_ok) begin
					nack_d = 1'b0;
					busy_d = 1'b1;
					state_d = QPC_START;
					phase_d = 2'd0;
				end
			end
		end else if (tick) begin
			phase_d = phase_q + 2'd1;
			unique case (state_q)
				QPC_START: begin
					// data falls while clock is high, then clock falls
					if (phase_q == 2'd0) begin
						scl_d = 1'b1;
						low_d = 1'b0;
					end
					if (phase_q == 2'd1) low_d = 1'b1;
					if (phase_q == 2'd2) scl_d = 1'b0;
					if (phase_q == 2'd3) begin
						state_d = QPC_BITS;
						sh_d = id_byte;
						bitn_d = 3'd7;
						bidx_d = 2'd0;
						rx_d = 1'b0;
					end
				end
				QPC_BITS: begin
					// msb first; reads release the line and sample mid-high
					if (phase_q == 2'd0) low_d = ~rx_q & ~sh_q[7];
					if (phase_q == 2'd1) scl_d = 1'b1;
					if (phase_q == 2'd2) sh_d = {sh_q[6:0], rx_q & sda_s};
					if (phase_q == 2'd3) begin
						scl_d = 1'b0;
						if (bitn_q == 3'd0) state_d = QPC_ACK;
						bitn_d = bitn_q - 3'd1;
					end
				end
				QPC_ACK: begin
					// master acks read data, otherwise listen for the device
					if (phase_q == 2'd0) low_d = rx_q;
					if (phase_q == 2'd1) scl_d = 1'b1;
					if (phase_q == 2'd2 && !rx_q) nack_d = sda_s;
					if (phase_q == 2'd2 && rx_q) rdata_d = sh_q;
					if (phase_q == 2'd3) begin
						scl_d = 1'b0;
						bidx_d = bidx_q + 2'd1;
						bitn_d = 3'd7;
						rx_d = op_read & (bidx_q == 2'd1);
						sh_d = (bidx_q == 2'd0) ? ins_byte : wr_byte;
						cnt_d = step_q[STEP_W-1:0];
						if (nack_q) state_d = QPC_STOP;
						else if (op_step && bidx_q == 2'd1) state_d = QPC_STEP;
						else if (last_byte) state_d = QPC_STOP;
						else state_d = QPC_BITS;
					end
				end
				QPC_STEP: begin
					// level held through the whole high phase of each pulse
					if (phase_q == 2'd0) begin
						if (cnt_q == '0) begin
							state_d = QPC_STOP;
							phase_d = 2'd0;
						end else begin
							low_d = ~step_up;
						end
					end
					if (phase_q == 2'd1) scl_d = 1'b1;
					if (phase_q == 2'd3) begin
						scl_d = 1'b0;
						cnt_d = cnt_q - STEP_W'(1);
					end
				end
				QPC_STOP: begin
					// data rises while clock is high
					if (phase_q == 2'd0) low_d = 1'b1;
					if (phase_q == 2'd1) scl_d = 1'b1;
					if (phase_q == 2'd2) low_d = 1'b0;
					if (phase_q == 2'd3) begin
						state_d = QPC_IDLE;
						busy_d = 1'b0;
					end
				end
				default: begin
					state_d = QPC_IDLE;
					busy_d = 1'b0;
					scl_d = 1'b1;
					low_d = 1'b0;
				end
			endcase
		end
	end

	// ************************************************************
	// frame sequencer registers and pins
	// ************************************************************
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			state_q <= QPC_IDLE;
			phase_q <= 2'd0;
			bitn_q <= 3'd7;
			bidx_q <= 2'd0;
			sh_q <= 8'h00;
			cnt_q <= '0;
			rx_q <= 1'b0;
			busy_q <= 1'b0;
		end else begin
			state_q <= state_d;
			phase_q <= phase_d;
			bitn_q <= bitn_d;
			bidx_q <= bidx_d;
			sh_q <= sh_d;
			cnt_q <= cnt_d;
			rx_q <= rx_d;
			busy_q <= busy_d;
		end
	end

	// status flags and the open-drain pins; the pin only ever pulls low
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			nack_q <= 1'b0;
			badop_q <= 1'b0;
			rdata_q <= 8'h00;
			scl_o <= 1'b1;
			low_q <= 1'b0;
			sda_o <= 1'b0;
			sda_oe <= 1'b0;
		end else begin
			nack_q <= nack_d;
			badop_q <= badop_d;
			rdata_q <= rdata_d;
			scl_o <= scl_d;
			low_q <= low_d;
			sda_o <= 1'b0;
			sda_oe <= low_d;
		end
	end
endmodule

// >>> src/qpc_pkg.sv
// constants shared by the quad pot frame controller
// assumes one 200 MHz system clock and a 32-bit AHB-Lite register port
package qpc_pkg;
	// ************************************************************
	// register map
	// ************************************************************
	localparam logic [7:0] QPC_CMD_OFF = 8'h00;
	localparam logic [7:0] QPC_STEP_OFF = 8'h04;
	localparam logic [7:0] QPC_STAT_OFF = 8'h08;
	localparam int QPC_CMD_GO_BIT = 31;
	localparam int QPC_STEP_UP_BIT = 16;
	localparam logic [31:0] QPC_CMD_RST = 32'h0000_0000;
	localparam logic [31:0] QPC_STEP_RST = 32'h0000_0000;

	// ************************************************************
	// instruction opcodes, upper nibble of the instruction byte
	// ************************************************************
	localparam logic [3:0] QPC_OP_RD_WIPER = 4'h9;
	localparam logic [3:0] QPC_OP_WR_WIPER = 4'hA;
	localparam logic [3:0] QPC_OP_RD_STORED = 4'hB;
	localparam logic [3:0] QPC_OP_WR_STORED = 4'hC;
	localparam logic [3:0] QPC_OP_LOAD_ONE = 4'hD;
	localparam logic [3:0] QPC_OP_SAVE_ONE = 4'hE;
	localparam logic [3:0] QPC_OP_LOAD_ALL = 4'h1;
	localparam logic [3:0] QPC_OP_SAVE_ALL = 4'h8;
	localparam logic [3:0] QPC_OP_STEP = 4'h2;

	// ************************************************************
	// link timing
	// ************************************************************
	localparam int QPC_CLK_MHZ = 200;
	localparam int QPC_SCL_PERIOD_NS = 2500;
	// one bit is four quarters; longest quarter rounds down
	localparam int QPC_QUARTER_CYC = QPC_SCL_PERIOD_NS * QPC_CLK_MHZ / 4000;

	// frame sequencer, gray codes along idle-start-bits-ack-stop
	typedef enum logic [2:0] {
		QPC_IDLE = 3'b000,
		QPC_START = 3'b001,
		QPC_BITS = 3'b011,
		QPC_ACK = 3'b010,
		QPC_STOP = 3'b110,
		QPC_STEP = 3'b111
	} qpc_state_t;
endpackage

// >>> src/qpc_sync.sv
// two-stage synchroniser for levels arriving from outside hclk
// assumes the input is a slow level; no pulse shorter than two cycles
`timescale 1ns/1ps
module qpc_sync #(
	parameter int WIDTH = 1
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [WIDTH-1:0] async_in,
	output logic [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_q;

	// ************************************************************
	// first stage feeds only the second
	// ************************************************************
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			meta_q <= '0;
			sync_out <= '0;
		end else begin
			meta_q <= async_in;
			sync_out <= meta_q;
		end
	end
endmodule

// >>> verif/qpc_host_asserts.sv
// concurrent checks on the quad pot host ports
// assumes one hclk domain with async active-low hresetn
`timescale 1ns/1ps
module qpc_host_asserts (
	input wire logic hclk,
	input wire logic hresetn,
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic hready,
	input wire logic [31:0] hrdata,
	input wire logic hreadyout,
	input wire logic hresp,
	input wire logic scl_o,
	input wire logic sda_o,
	input wire logic sda_oe
);
	// ****************************************
	// bus and link properties
	// ****************************************
	default clocking @(posedge hclk); endclocking
	default disable iff (!hresetn);
	sequence rd_taken;
		hsel && hready && htrans[1] && !hwrite;
	endsequence
	sequence scl_edge;
		$rose(scl_o) || $fell(scl_o);
	endsequence
	hready_high_a: assert property (hreadyout == 1'b1)
		else $error("wait state inserted");
	okay_resp_a: assert property (hresp == 1'b0)
		else $error("error response");
	sda_zero_a: assert property (sda_o == 1'b0)
		else $error("sda value not low");
	rdata_idle_a: assert property (!(hsel && hready && htrans[1] && !hwrite) |=> hrdata == 32'h0)
		else $error("read data outside data phase");
	unmapped_rd_a: assert property (rd_taken ##0 (haddr[7:0] > 8'h08) |=> hrdata == 32'h0)
		else $error("unmapped read not zero");
	scl_hold_a: assert property ($changed(scl_o) |=> $stable(scl_o) [*3])
		else $error("scl level shorter than a quarter");
	oe_hold_a: assert property ($changed(sda_oe) |=> $stable(sda_oe) [*3])
		else $error("sda level shorter than a quarter");
	edge_apart_a: assert property (scl_edge |-> $stable(sda_oe))
		else $error("sda moved on an scl edge");
endmodule

bind qpc_host qpc_host_asserts chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
	.htrans(htrans), .hwrite(hwrite), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout),
	.hresp(hresp), .scl_o(scl_o), .sda_o(sda_o), .sda_oe(sda_oe));

// >>> verif/qpc_dev.sv
// behavioural quad pot device on the 2-wire link
// assumes an open-drain sda with pull-up; pull=1 drives it low
`timescale 1ns/1ps
module qpc_dev #(
	parameter logic [3:0] DEV_TYPE = 4'h6, // arbitrary value
	parameter logic [3:0] ADDR = 4'h5
) (
	input wire logic scl,
	input wire logic sda,
	output logic pull
);
	import qpc_pkg::*;
	logic [7:0] wiper [4];
	logic [7:0] stored [4][4];
	logic [7:0] sh, tx;
	logic [3:0] op;
	logic [1:0] sel, pot;
	logic act, stp, up;
	int nbit, nbyte;
	// ****************************************
	// frame decoding
	// ****************************************
	// power-up state; nonvolatile busy time is not modelled
	initial begin
		pull = 0;
		act = 0;
		stp = 0;
		foreach (wiper[i]) wiper[i] = 8'h00;
		foreach (stored[i, j]) stored[i][j] = 8'h00;
	end
	// start and stop conditions
	always @(negedge sda) if (scl) begin
		act = 1;
		stp = 0;
		nbit = -1; // start's own scl fall is not a bit
		nbyte = 0;
	end
	always @(posedge sda) if (scl) begin
		act = 0;
		stp = 0;
		pull = 0;
	end
	// sample on the high phase
	always @(posedge scl) if (act) begin
		if (stp) up = sda;
		else if (nbit >= 0 && nbit < 8) sh = {sh[6:0], sda};
	end
	// act on the falling edge, so a stop never counts as a step
	always @(negedge scl) if (act) begin
		if (stp) begin
			if (up && wiper[pot] != 8'hFF) wiper[pot]++;
			else if (!up && wiper[pot] != 8'h00) wiper[pot]--;
		end else begin
			nbit++;
			if (nbit == 8 && nbyte == 0) begin
				act = (sh == {DEV_TYPE, ADDR});
				pull = act;
			end else if (nbit == 8 && nbyte == 1) begin
				{op, sel, pot} = sh;
				pull = 1;
				case (op)
					QPC_OP_RD_WIPER: tx = wiper[pot];
					QPC_OP_RD_STORED: tx = stored[pot][sel];
					QPC_OP_LOAD_ONE: wiper[pot] = stored[pot][sel];
					QPC_OP_SAVE_ONE: stored[pot][sel] = wiper[pot];
					QPC_OP_LOAD_ALL: foreach (wiper[i]) wiper[i] = stored[i][sel];
					QPC_OP_SAVE_ALL: foreach (wiper[i]) stored[i][sel] = wiper[i];
					default: ;
				endcase
			end else if (nbit == 8) begin
				pull = (op == QPC_OP_WR_WIPER || op == QPC_OP_WR_STORED);
				if (op == QPC_OP_WR_WIPER) wiper[pot] = sh;
				if (op == QPC_OP_WR_STORED) stored[pot][sel] = sh;
			end else if (nbit == 9) begin
				pull = 0;
				nbit = 0;
				nbyte++;
				stp = (nbyte == 2 && op == QPC_OP_STEP);
			end
			if (nbyte == 2 && nbit < 8 && (op == QPC_OP_RD_WIPER || op == QPC_OP_RD_STORED))
				pull = !tx[7 - nbit];
		end
	end
endmodule

// >>> verif/testbench.sv
// self-checking bench for the quad pot host controller
// assumes the behavioural device model and a short link quarter
`timescale 1ns/1ps
module testbench;
	import qpc_pkg::*;
	localparam logic [3:0] ADR = 4'h5;
	logic hclk, hresetn, hsel, hwrite, sda_i, scl_o, sda_o, sda_oe, hreadyout, hresp, pull;
	logic [31:0] haddr, hwdata, hrdata, rd;
	logic [1:0] htrans;
	logic [2:0] hsize;
	int num_errors, comparisons;
	// ****************************************
	// wiring
	// ****************************************
	// open-drain wire with pull-up
	assign sda_i = (sda_oe ? sda_o : 1'b1) && !pull;
	qpc_host #(.QUARTER_CYC(4)) uut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
		.hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
		.scl_o(scl_o), .sda_i(sda_i), .sda_o(sda_o), .sda_oe(sda_oe));
	qpc_dev #(.ADDR(ADR)) dev (.scl(scl_o), .sda(sda_i), .pull(pull));
	// ****************************************
	// tasks
	// ****************************************
	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// ready and read data are taken at the rising edge that ends each phase
	task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd);
		hsel <= 1;
		haddr <= {24'h0, a};
		hwrite <= w;
		hsize <= 3'b010;
		htrans <= 2'b10;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		htrans <= 2'b00;
		hwdata <= wd;
		do @(posedge hclk); while (hreadyout !== 1'b1);
		rd = hrdata;
	endtask
	task automatic frame(input logic [3:0] op, sa, input logic [1:0] sel, pot, input logic [7:0] d);
		int n;
		ahb(1, QPC_CMD_OFF, {1'b1, 11'h0, sa, d, pot, sel, op});
		repeat (3) @(posedge hclk);
		n = 0;
		do begin
			ahb(0, QPC_STAT_OFF, 32'h0);
			n++;
		end while (rd[0] !== 1'b0 && n < 2000);
		// a frame that never ends counts as a mismatch
		check("frame done", 32'(rd[0]), 32'h0);
	endtask
	task automatic rdchk(input string nm, input logic [3:0] op, input logic [1:0] sel, pot,
			input logic [7:0] exp);
		frame(op, ADR, sel, pot, 8'h00);
		check(nm, 32'({rd[15:8], rd[2:0]}), 32'({exp, 3'b000}));
	endtask
	task automatic complete_run;
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	// ****************************************
	// clock, watchdog and tests
	// ****************************************
	initial begin
		hclk = 0;
		forever #2.5 hclk = ~hclk;
	end
	// the whole run takes about 42 us
	initial begin
		#400000;
		num_errors++;
		complete_run;
	end
	initial begin
		num_errors = 0;
		comparisons = 0;
		hresetn = 0;
		{hsel, hwrite, htrans, haddr, hwdata} = '0;
		hsize = 3'b010;
		repeat (20) @(posedge hclk);
		hresetn <= 1;
		@(posedge hclk);
		ahb(0, QPC_STAT_OFF, 32'h0);
		check("status", rd, 32'h0);
		ahb(0, QPC_CMD_OFF, 32'h0);
		check("cmd", rd, QPC_CMD_RST);
		ahb(0, 8'h0C, 32'h0);
		check("unmapped", rd, 32'h0);
		$display("test reset done");
		frame(QPC_OP_WR_WIPER, ADR, 0, 2, 8'hA5);
		rdchk("wiper2", QPC_OP_RD_WIPER, 0, 2, 8'hA5);
		frame(QPC_OP_WR_STORED, ADR, 3, 1, 8'h3C);
		rdchk("stored31", QPC_OP_RD_STORED, 3, 1, 8'h3C);
		frame(QPC_OP_LOAD_ONE, ADR, 3, 1, 8'h00);
		rdchk("wiper1", QPC_OP_RD_WIPER, 0, 1, 8'h3C);
		frame(QPC_OP_SAVE_ONE, ADR, 1, 2, 8'h00);
		rdchk("stored12", QPC_OP_RD_STORED, 1, 2, 8'hA5);
		$display("test single transfers done");
		frame(QPC_OP_SAVE_ALL, ADR, 2, 0, 8'h00);
		frame(QPC_OP_WR_WIPER, ADR, 0, 2, 8'h00);
		frame(QPC_OP_LOAD_ALL, ADR, 2, 0, 8'h00);
		rdchk("wiper2 load", QPC_OP_RD_WIPER, 0, 2, 8'hA5);
		rdchk("stored21", QPC_OP_RD_STORED, 2, 1, 8'h3C);
		$display("test global transfers done");
		frame(QPC_OP_WR_WIPER, ADR, 0, 3, 8'hFD);
		ahb(1, QPC_STEP_OFF, 32'h0001_0005);
		frame(QPC_OP_STEP, ADR, 0, 3, 8'h00);
		rdchk("step up", QPC_OP_RD_WIPER, 0, 3, 8'hFF);
		ahb(1, QPC_STEP_OFF, 32'h0000_0003);
		ahb(0, QPC_STEP_OFF, 32'h0);
		check("step reg", rd, 32'h0000_0003);
		frame(QPC_OP_STEP, ADR, 0, 3, 8'h00);
		rdchk("step down", QPC_OP_RD_WIPER, 0, 3, 8'hFC);
		$display("test stepping done");
		frame(4'h3, ADR, 0, 0, 8'h00);
		check("bad op", 32'(rd[2]), 32'h1);
		frame(QPC_OP_RD_WIPER, ~ADR, 0, 0, 8'h00);
		check("nack", 32'(rd[1]), 32'h1);
		rdchk("after nack", QPC_OP_RD_WIPER, 0, 1, 8'h3C);
		$display("test refusals done");
		complete_run;
	end
endmodule
